//--- verilog/sci_pkg.sv
/*
 * Package for the sideband channel initial-state controller:
 * command and answer carriers, codes, register offsets, reset values.
 * Assumes a single clock domain and a command decoder on the same clock.
 */
package sci_pkg;

    // ***************************************************
    // Sizes
    // ***************************************************
    localparam int         NUM_CH  = 4;
    localparam logic [4:0] PKG_CH  = 5'h1f;
    localparam logic [2:0] PKG_ID  = 3'h0;

    // ***************************************************
    // Opcodes
    // ***************************************************
    localparam logic [7:0] OP_CLEAR_INIT = 8'h00;
    localparam logic [7:0] OP_SELECT     = 8'h01;
    localparam logic [7:0] OP_DESELECT   = 8'h02;
    localparam logic [7:0] OP_CH_ENABLE  = 8'h03;
    localparam logic [7:0] OP_CH_DISABLE = 8'h04;
    localparam logic [7:0] OP_CH_RESET   = 8'h05;
    localparam logic [7:0] OP_TX_ENABLE  = 8'h06;
    localparam logic [7:0] OP_TX_DISABLE = 8'h07;
    localparam logic [7:0] OP_AEN_ENABLE = 8'h08;
    localparam logic [7:0] OP_SET_FILT   = 8'h0a;
    localparam logic [7:0] OP_OEM        = 8'h50;

    // ***************************************************
    // Answer codes
    // ***************************************************
    localparam logic [15:0] RC_OK       = 16'h0000;
    localparam logic [15:0] RC_FAILED   = 16'h0001;
    localparam logic [15:0] RC_UNSUPP   = 16'h0003;
    localparam logic [15:0] RS_NONE     = 16'h0000;
    localparam logic [15:0] RS_INIT_REQ = 16'h0001;
    localparam logic [15:0] RS_BAD_PARM = 16'h0002;
    localparam logic [15:0] RS_BAD_OP   = 16'h7fff;

    // ***************************************************
    // Register map and reset values
    // ***************************************************
    localparam logic [7:0] OFS_STATUS = 8'h00;
    localparam logic [7:0] OFS_FORCE  = 8'h04;
    localparam logic [7:0] OFS_FILT   = 8'h08;
    localparam logic [7:0] OFS_CNT0   = 8'h10;
    localparam logic       ARB_RST    = 1'b1;
    localparam logic [7:0] FILT_RST   = 8'h00;
    localparam logic [15:0] CNT_RST   = 16'h0000;

    typedef enum logic {CH_INIT, CH_READY} sci_ch_state_t;

    typedef struct packed {
        logic [2:0] pkg;
        logic [4:0] ch;
        logic [7:0] op;
        logic [7:0] iid;
        logic [7:0] arg;
    } sci_cmd_t;

    typedef struct packed {
        logic [4:0]  ch;
        logic [7:0]  op;
        logic [7:0]  iid;
        logic [15:0] code;
        logic [15:0] reason;
        logic        retry;
    } sci_rsp_t;

endpackage : sci_pkg

//--- verilog/sci_ctrl.sv
/*
 * Channel and package state control with command answers and a small
 * register port. Assumes commands come decoded on MCLK; event, token,
 * power and link inputs are pins and are synchronised here.
 */
`timescale 1ns/100ps

module sci_ctrl (
    input  wire logic                 MCLK,
    input  wire logic                 RST,
    input  wire logic                 CMD_VALID,
    input  wire sci_pkg::sci_cmd_t    CMD,
    output      logic                 RSP_VALID,
    output      sci_pkg::sci_rsp_t    RSP,
    input  wire logic                 PWR_UP,
    input  wire logic                 PKG_EVT,
    input  wire logic [3:0]           CH_EVT,
    input  wire logic                 ARB_TOKEN,
    input  wire logic                 LINK_UP,
    input  wire logic [3:0]           PT_FRAME,
    output      logic                 TX_ALLOW,
    output      logic [3:0]           PT_TX_EN,
    output      logic [3:0]           AEN_TX_EN,
    output      logic [3:0]           CH_IN_INIT,
    output      logic                 LINK_STAT,
    input  wire logic [7:0]           ADDR,
    input  wire logic [31:0]          WDATA,
    input  wire logic                 WR,
    input  wire logic                 RD,
    output      logic [31:0]          RDATA
);

    localparam int N = sci_pkg::NUM_CH;

    // ***************************************************
    // Pin synchronisers
    // ***************************************************
    logic [7:0] sync1_reg;
    logic [7:0] sync2_reg;
    logic       pwr_last_reg;
    logic       pwr_s;
    logic       pkg_s;
    logic [3:0] evt_s;
    logic       tok_s;
    logic       link_s;
    logic       pwr_rise;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            sync1_reg    <= 8'h00;
            sync2_reg    <= 8'h00;
            pwr_last_reg <= 1'b0;
        end else begin
            sync1_reg    <= {LINK_UP, ARB_TOKEN, CH_EVT, PKG_EVT, PWR_UP};
            sync2_reg    <= sync1_reg;
            pwr_last_reg <= pwr_s;
        end
    end

    assign pwr_s    = sync2_reg[0];
    assign pkg_s    = sync2_reg[1];
    assign evt_s    = sync2_reg[5:2];
    assign tok_s    = sync2_reg[6];
    assign link_s   = sync2_reg[7];
    assign pwr_rise = pwr_s & ~pwr_last_reg;

    // ***************************************************
    // Command decode
    // ***************************************************
    logic       mine;
    logic       is_pkg;
    logic       ch_ok;
    logic [1:0] ci;
    logic [3:0] force_reg;
    logic [3:0] reset_cmd;
    logic [3:0] entry;
    logic [3:0] async_entry;
    logic [3:0] ch_hit;
    logic [3:0] clear_ok;
    logic [3:0] run_ok;

    sci_pkg::sci_ch_state_t st_reg [N];
    logic [7:0] iid_reg [N];
    logic [3:0] iid_ok_reg;

    assign mine   = CMD_VALID && CMD.pkg == sci_pkg::PKG_ID;
    assign is_pkg = CMD.ch == sci_pkg::PKG_CH;
    assign ch_ok  = !is_pkg && CMD.ch < 5'(N);
    assign ci     = CMD.ch[1:0];

    always_comb begin
        for (int c = 0; c < N; c++) begin
            ch_hit[c]      = mine && ch_ok && ci == 2'(c);
            // Entry from pins, package event, power-up, software force
            async_entry[c] = pwr_rise | pkg_s | evt_s[c] | force_reg[c];
            clear_ok[c]    = ch_hit[c] && CMD.op == sci_pkg::OP_CLEAR_INIT;
            run_ok[c]      = ch_hit[c] && st_reg[c] == sci_pkg::CH_READY
                             && !async_entry[c];
            reset_cmd[c]   = run_ok[c] && CMD.op == sci_pkg::OP_CH_RESET;
            entry[c]       = async_entry[c] | reset_cmd[c];
        end
    end

    // ***************************************************
    // Channel state machines
    // ***************************************************
    logic [3:0] en_reg;
    logic [3:0] tx_reg;
    logic [3:0] aen_reg;
    logic [7:0] filt_reg [N];

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            for (int c = 0; c < N; c++) begin
                st_reg[c] <= sci_pkg::CH_INIT;
            end
        end else begin
            for (int c = 0; c < N; c++) begin
                case (st_reg[c])
                    sci_pkg::CH_INIT: begin
                        if (clear_ok[c] && !entry[c]) begin
                            st_reg[c] <= sci_pkg::CH_READY;
                        end
                    end
                    sci_pkg::CH_READY: begin
                        if (entry[c]) begin
                            st_reg[c] <= sci_pkg::CH_INIT;
                        end
                    end
                    default: st_reg[c] <= sci_pkg::CH_INIT;
                endcase
            end
        end
    end

    // Per-channel settings forced on entry, others kept
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            en_reg  <= 4'h0;
            tx_reg  <= 4'h0;
            aen_reg <= 4'h0;
            for (int c = 0; c < N; c++) begin
                filt_reg[c] <= sci_pkg::FILT_RST;
            end
        end else begin
            for (int c = 0; c < N; c++) begin
                if (entry[c]) begin
                    en_reg[c]   <= 1'b0;
                    tx_reg[c]   <= 1'b0;
                    aen_reg[c]  <= 1'b0;
                    filt_reg[c] <= sci_pkg::FILT_RST;
                end else if (run_ok[c]) begin
                    case (CMD.op)
                        sci_pkg::OP_CH_ENABLE:  en_reg[c]   <= 1'b1;
                        sci_pkg::OP_CH_DISABLE: en_reg[c]   <= 1'b0;
                        sci_pkg::OP_TX_ENABLE:  tx_reg[c]   <= 1'b1;
                        sci_pkg::OP_TX_DISABLE: tx_reg[c]   <= 1'b0;
                        sci_pkg::OP_AEN_ENABLE: aen_reg[c]  <= CMD.arg[0];
                        sci_pkg::OP_SET_FILT:   filt_reg[c] <= CMD.arg;
                        default:                en_reg[c]   <= en_reg[c];
                    endcase
                end
            end
        end
    end

    // Instance identifier memory
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            iid_ok_reg <= 4'h0;
            for (int c = 0; c < N; c++) begin
                iid_reg[c] <= 8'h00;
            end
        end else begin
            for (int c = 0; c < N; c++) begin
                if (entry[c]) begin
                    iid_ok_reg[c] <= 1'b0;
                end else if (ch_hit[c]) begin
                    iid_ok_reg[c] <= 1'b1;
                    iid_reg[c]    <= CMD.iid;
                end
            end
        end
    end

    // ***************************************************
    // Package state
    // ***************************************************
    logic sel_reg;
    logic arb_reg;

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            sel_reg <= 1'b0;
            arb_reg <= sci_pkg::ARB_RST;
        end else begin
            if (pwr_rise) begin
                arb_reg <= 1'b1;
            end else if (mine && is_pkg && CMD.op == sci_pkg::OP_SELECT) begin
                arb_reg <= ~CMD.arg[0];
            end
            if (mine && is_pkg && CMD.op == sci_pkg::OP_SELECT) begin
                sel_reg <= 1'b1;
            end else if (mine && is_pkg && CMD.op == sci_pkg::OP_DESELECT) begin
                sel_reg <= 1'b0;
            end
        end
    end

    // ***************************************************
    // Statistics counters
    // ***************************************************
    logic [15:0] cmd_cnt_reg [N];
    logic [15:0] pt_cnt_reg [N];

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            for (int c = 0; c < N; c++) begin
                cmd_cnt_reg[c] <= sci_pkg::CNT_RST;
                pt_cnt_reg[c]  <= sci_pkg::CNT_RST;
            end
        end else begin
            for (int c = 0; c < N; c++) begin
                if (entry[c]) begin
                    cmd_cnt_reg[c] <= sci_pkg::CNT_RST;
                    pt_cnt_reg[c]  <= sci_pkg::CNT_RST;
                end else begin
                    cmd_cnt_reg[c] <= cmd_cnt_reg[c] + 16'(ch_hit[c]);
                    pt_cnt_reg[c]  <= pt_cnt_reg[c] + 16'(PT_FRAME[c] & PT_TX_EN[c]);
                end
            end
        end
    end

    // ***************************************************
    // Answers
    // ***************************************************
    function automatic logic known_op(input logic [7:0] op);
        known_op = op <= sci_pkg::OP_SET_FILT && op != 8'h09;
    endfunction : known_op

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            RSP_VALID <= 1'b0;
            RSP       <= '0;
        end else begin
            RSP_VALID  <= mine && (is_pkg || ch_ok || CMD.ch < 5'h1f);
            RSP.ch     <= CMD.ch;
            RSP.op     <= CMD.op;
            RSP.iid    <= CMD.iid;
            RSP.retry  <= ch_ok && iid_ok_reg[ci] && iid_reg[ci] == CMD.iid;
            RSP.code   <= sci_pkg::RC_OK;
            RSP.reason <= sci_pkg::RS_NONE;
            if (is_pkg) begin
                if (CMD.op != sci_pkg::OP_SELECT && CMD.op != sci_pkg::OP_DESELECT) begin
                    RSP.code   <= sci_pkg::RC_UNSUPP;
                    RSP.reason <= sci_pkg::RS_BAD_OP;
                end
            end else if (!ch_ok) begin
                RSP.code   <= sci_pkg::RC_FAILED;
                RSP.reason <= sci_pkg::RS_BAD_PARM;
            end else if (CMD.op == sci_pkg::OP_OEM) begin
                RSP.code <= sci_pkg::RC_OK;
            end else if (st_reg[ci] == sci_pkg::CH_INIT) begin
                if (CMD.op != sci_pkg::OP_CLEAR_INIT) begin
                    RSP.code   <= sci_pkg::RC_FAILED;
                    RSP.reason <= sci_pkg::RS_INIT_REQ;
                end
            end else if (!known_op(CMD.op)) begin
                RSP.code   <= sci_pkg::RC_UNSUPP;
                RSP.reason <= sci_pkg::RS_BAD_OP;
            end
        end
    end

    // ***************************************************
    // Transmit permission
    // ***************************************************
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            TX_ALLOW   <= 1'b0;
            PT_TX_EN   <= 4'h0;
            AEN_TX_EN  <= 4'h0;
            CH_IN_INIT <= 4'hf;
            LINK_STAT  <= 1'b0;
        end else begin
            TX_ALLOW  <= sel_reg && (!arb_reg || tok_s);
            LINK_STAT <= link_s;
            for (int c = 0; c < N; c++) begin
                CH_IN_INIT[c] <= st_reg[c] == sci_pkg::CH_INIT;
                PT_TX_EN[c]   <= !entry[c] && st_reg[c] == sci_pkg::CH_READY
                                 && en_reg[c] && tx_reg[c];
                AEN_TX_EN[c]  <= !entry[c] && st_reg[c] == sci_pkg::CH_READY
                                 && en_reg[c] && aen_reg[c];
            end
        end
    end

    // ***************************************************
    // Register port
    // ***************************************************
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            force_reg <= 4'h0;
            RDATA     <= 32'h0;
        end else begin
            force_reg <= (WR && ADDR == sci_pkg::OFS_FORCE) ? WDATA[3:0] : 4'h0;
            RDATA     <= 32'h0;
            if (RD) begin
                if (ADDR == sci_pkg::OFS_STATUS) begin
                    RDATA <= {20'h0, arb_reg, sel_reg, link_s, tok_s,
                              en_reg, CH_IN_INIT};
                end else if (ADDR == sci_pkg::OFS_FILT) begin
                    RDATA <= {filt_reg[3], filt_reg[2], filt_reg[1], filt_reg[0]};
                end else if (ADDR[7:4] == sci_pkg::OFS_CNT0[7:4]) begin
                    RDATA <= {pt_cnt_reg[ADDR[3:2]], cmd_cnt_reg[ADDR[3:2]]};
                end
            end
        end
    end

    // ***************************************************
    // Checks
    // ***************************************************
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (RST);

    a_init_exit_only: assert property (
        st_reg[0] == sci_pkg::CH_INIT && !clear_ok[0] |=> st_reg[0] == sci_pkg::CH_INIT)
        else $error("channel left initial without clear");
    a_init_fail_rsp: assert property (
        mine && ch_ok && st_reg[ci] == sci_pkg::CH_INIT
        && CMD.op != sci_pkg::OP_CLEAR_INIT && CMD.op != sci_pkg::OP_OEM
        |=> RSP_VALID && RSP.code == sci_pkg::RC_FAILED
            && RSP.reason == sci_pkg::RS_INIT_REQ)
        else $error("initial channel did not fail command");
    a_clear_ok_rsp: assert property (
        clear_ok[1] && !entry[1] |=> RSP.code == sci_pkg::RC_OK
            && st_reg[1] == sci_pkg::CH_READY)
        else $error("clear did not succeed");
    a_pkg_answered: assert property (
        mine && is_pkg && CMD.op == sci_pkg::OP_DESELECT
        |=> RSP_VALID && RSP.code == sci_pkg::RC_OK ##1 !TX_ALLOW)
        else $error("deselect not answered normally");
    a_tx_needs_sel: assert property (
        TX_ALLOW |-> $past(sel_reg) && (!$past(arb_reg) || $past(tok_s)))
        else $error("transmit without selection or token");
    a_entry_quiets: assert property (
        entry[2] |=> !tx_reg[2] && !aen_reg[2] && !PT_TX_EN[2]
            && cmd_cnt_reg[2] == 16'h0)
        else $error("entry left channel transmitting");
    a_evt_to_init: assert property (
        evt_s[2] |=> st_reg[2] == sci_pkg::CH_INIT)
        else $error("event did not force initial");
    a_arb_kept: assert property (
        !pwr_rise && !(mine && is_pkg) |=> $stable(arb_reg))
        else $error("arbitration setting changed");
    a_link_kept: assert property (
        $stable(link_s) |=> LINK_STAT == $past(link_s))
        else $error("link state disturbed");

endmodule : sci_ctrl

//--- tb/sci_mc_model.sv
/*
 * Management controller model: issues sideband commands and takes answers.
 * Assumes commands are taken on MCLK and answered one cycle later.
 */
`timescale 1ns/100ps

module sci_mc_model (
    input  wire logic              MCLK,
    input  wire logic              RST,
    output      logic              CMD_VALID,
    output      sci_pkg::sci_cmd_t CMD,
    input  wire logic              RSP_VALID,
    input  wire sci_pkg::sci_rsp_t RSP
);

    initial begin
        CMD_VALID = 1'b0;
        CMD       = '0;
    end

    // ***************************************************
    // Command issue
    // ***************************************************
    task automatic send(input logic [4:0] ch, input logic [7:0] op, input logic [7:0] iid,
                        input logic [7:0] arg,
                        output logic got, output sci_pkg::sci_rsp_t rsp);
        sci_pkg::sci_cmd_t c;
        c = {sci_pkg::PKG_ID, ch, op, iid, arg};
        @(posedge MCLK);
        CMD_VALID <= 1'b1;
        CMD       <= c;
        @(posedge MCLK);
        CMD_VALID <= 1'b0;
        CMD       <= ~c;
        #1;
        got = RSP_VALID;
        rsp = RSP; // Only defined answer fields used
    endtask : send

endmodule : sci_mc_model

//--- tb/tb.sv
/*
 * Testbench for the channel state controller: commands via the controller
 * model, registers via the plain port. Assumes a 125 MHz MCLK.
 */
`timescale 1ns/100ps

module tb;
    logic MCLK, RST, CMD_VALID, RSP_VALID, PWR_UP, PKG_EVT, ARB_TOKEN, LINK_UP;
    logic TX_ALLOW, LINK_STAT, WR, RD;
    logic [3:0] CH_EVT, PT_FRAME, PT_TX_EN, AEN_TX_EN, CH_IN_INIT;
    logic [7:0] ADDR;
    logic [31:0] WDATA, RDATA, d;
    sci_pkg::sci_cmd_t CMD;
    sci_pkg::sci_rsp_t RSP;
    int num_errors, comparisons, cycles;
    logic [7:0] refused[9] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0a};

    sci_ctrl DUT (.MCLK(MCLK), .RST(RST), .CMD_VALID(CMD_VALID), .CMD(CMD),
        .RSP_VALID(RSP_VALID), .RSP(RSP), .PWR_UP(PWR_UP), .PKG_EVT(PKG_EVT),
        .CH_EVT(CH_EVT), .ARB_TOKEN(ARB_TOKEN), .LINK_UP(LINK_UP), .PT_FRAME(PT_FRAME),
        .TX_ALLOW(TX_ALLOW), .PT_TX_EN(PT_TX_EN), .AEN_TX_EN(AEN_TX_EN),
        .CH_IN_INIT(CH_IN_INIT), .LINK_STAT(LINK_STAT), .ADDR(ADDR), .WDATA(WDATA),
        .WR(WR), .RD(RD), .RDATA(RDATA));

    sci_mc_model mc (.MCLK(MCLK), .RST(RST), .CMD_VALID(CMD_VALID), .CMD(CMD),
        .RSP_VALID(RSP_VALID), .RSP(RSP));

    // ***************************************************
    // Clock and timeout
    // ***************************************************
    initial begin
        MCLK = 1'b0;
        forever #4 MCLK = ~MCLK;
    end

    initial cycles = 0;
    always @(posedge MCLK) begin
        cycles++;
        if (cycles == 3000) begin
            num_errors++;
            give_verdict();
        end
    end

    // ***************************************************
    // Helpers
    // ***************************************************
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    task automatic settle(input int n);
        repeat (n) @(posedge MCLK);
        #1;
    endtask : settle

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge MCLK);
        ADDR  <= a;
        WDATA <= v;
        WR    <= 1'b1;
        @(posedge MCLK);
        WR    <= 1'b0;
    endtask : reg_wr

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge MCLK);
        ADDR <= a;
        RD   <= 1'b1;
        @(posedge MCLK);
        RD   <= 1'b0;
        #1;
        v = RDATA;
    endtask : reg_rd

    task automatic cmd(input logic [4:0] ch, input logic [7:0] op, input logic [7:0] iid,
                       input logic [15:0] code, input logic [15:0] rsn, input logic rtr,
                       input logic [7:0] arg = 8'h01);
        logic got;
        sci_pkg::sci_rsp_t r;
        mc.send(ch, op, iid, arg, got, r);
        chk("answer valid", 32'h1, 32'(got));
        chk("answer channel", 32'(ch), 32'(r.ch));
        chk("answer op", 32'(op), 32'(r.op));
        chk("answer iid", 32'(iid), 32'(r.iid));
        chk("answer code", 32'(code), 32'(r.code));
        chk("answer reason", 32'(rsn), 32'(r.reason));
        chk("answer retry", 32'(rtr), 32'(r.retry));
    endtask : cmd

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : give_verdict

    // ***************************************************
    // Scenarios
    // ***************************************************
    initial begin
        num_errors = 0;
        comparisons = 0;
        RST = 1'b1;
        {PWR_UP, PKG_EVT, ARB_TOKEN, LINK_UP, WR, RD} = '0;
        {CH_EVT, PT_FRAME, ADDR, WDATA} = '0;
        repeat (20) @(posedge MCLK);
        RST     <= 1'b0;
        LINK_UP <= 1'b1;
        settle(1);
        chk("init after reset", 32'hf, 32'(CH_IN_INIT));
        reg_rd(sci_pkg::OFS_STATUS, d);
        chk("status after reset", 32'h00000a0f, d);
        reg_rd(8'h3c, d);
        chk("unmapped read", 32'h0, d);
        reg_rd(sci_pkg::OFS_FILT, d);
        chk("filters after reset", 32'h0, d);
        foreach (refused[i])
            cmd(5'h01, refused[i], 8'(i), sci_pkg::RC_FAILED, sci_pkg::RS_INIT_REQ, 1'b0);
        cmd(5'h01, sci_pkg::OP_OEM, 8'h09, sci_pkg::RC_OK, sci_pkg::RS_NONE, 1'b0);
        cmd(5'h05, sci_pkg::OP_CH_ENABLE, 8'h01, sci_pkg::RC_FAILED, sci_pkg::RS_BAD_PARM, 1'b0);
        cmd(5'h1f, sci_pkg::OP_CH_ENABLE, 8'h02, sci_pkg::RC_UNSUPP, sci_pkg::RS_BAD_OP, 1'b0);
        cmd(5'h1f, sci_pkg::OP_SELECT, 8'h03, sci_pkg::RC_OK, sci_pkg::RS_NONE, 1'b0,
            8'h00);
        settle(4);
        chk("no token no tx", 32'h0, 32'(TX_ALLOW));
        ARB_TOKEN <= 1'b1;
        settle(5);
        chk("token and selected", 32'h1, 32'(TX_ALLOW));
        cmd(5'h1f, sci_pkg::OP_DESELECT, 8'h04, sci_pkg::RC_OK, sci_pkg::RS_NONE, 1'b0);
        settle(2);
        chk("deselected no tx", 32'h0, 32'(TX_ALLOW));
        // Select with arbitration off, token taken away
        ARB_TOKEN <= 1'b0;
        cmd(5'h1f, sci_pkg::OP_SELECT, 8'h05, sci_pkg::RC_OK, sci_pkg::RS_NONE, 1'b0);
        settle(5);
        chk("arb off selected tx", 32'h1, 32'(TX_ALLOW));
        chk("still in init", 32'hf, 32'(CH_IN_INIT));
        cmd(5'h00, sci_pkg::OP_CLEAR_INIT, 8'h10, sci_pkg::RC_OK, sci_pkg::RS_NONE, 1'b0);
        settle(1);
        chk("ch0 cleared alone", 32'he, 32'(CH_IN_INIT));
        // Controller restores settings after the initial-state clear
        cmd(5'h00, sci_pkg::OP_CH_ENABLE, 8'h11, sci_pkg::RC_OK, sci_pkg::RS_NONE, 1'b0);
        cmd(5'h00, sci_pkg::OP_TX_ENABLE, 8'h12, sci_pkg::RC_OK, sci_pkg::RS_NONE, 1'b0);
        cmd(5'h00, sci_pkg::OP_AEN_ENABLE, 8'h13, sci_pkg::RC_OK, sci_pkg::RS_NONE, 1'b0);
        cmd(5'h00, sci_pkg::OP_SET_FILT, 8'h14, sci_pkg::RC_OK, sci_pkg::RS_NONE, 1'b0);
        settle(1);
        chk("tx and notices on", 32'h3, 32'({PT_TX_EN[0], AEN_TX_EN[0]}));
        repeat (3) begin
            @(posedge MCLK);
            PT_FRAME <= 4'h1;
            @(posedge MCLK);
            PT_FRAME <= 4'h0;
        end
        reg_rd(sci_pkg::OFS_CNT0, d);
        chk("pass-through count", 32'h3, 32'(d[31:16]));
        chk("command count", 32'h5, 32'(d[15:0]));
        cmd(5'h00, sci_pkg::OP_TX_ENABLE, 8'h21, sci_pkg::RC_OK, sci_pkg::RS_NONE, 1'b0);
        cmd(5'h00, sci_pkg::OP_TX_ENABLE, 8'h21, sci_pkg::RC_OK, sci_pkg::RS_NONE, 1'b1);
        cmd(5'h00, sci_pkg::OP_CH_RESET, 8'h22, sci_pkg::RC_OK, sci_pkg::RS_NONE, 1'b0);
        settle(1);
        chk("reset channel entry", 32'hf, 32'(CH_IN_INIT));
        chk("tx notices off", 32'h0, 32'({PT_TX_EN, AEN_TX_EN}));
        chk("link untouched", 32'h1, 32'(LINK_STAT));
        reg_rd(sci_pkg::OFS_FILT, d);
        chk("filters cleared", 32'h0, d);
        reg_rd(sci_pkg::OFS_CNT0, d);
        chk("counters cleared", 32'h0, d);
        reg_rd(sci_pkg::OFS_STATUS, d);
        chk("arb kept off", 32'h0, 32'(d[11]));
        cmd(5'h00, sci_pkg::OP_CLEAR_INIT, 8'h31, sci_pkg::RC_OK, sci_pkg::RS_NONE, 1'b0);
        cmd(5'h00, sci_pkg::OP_CH_ENABLE, 8'h32, sci_pkg::RC_OK, sci_pkg::RS_NONE, 1'b0);
        reg_wr(sci_pkg::OFS_FORCE, 32'h1);
        settle(2);
        chk("forced entry", 32'hf, 32'(CH_IN_INIT));
        cmd(5'h00, sci_pkg::OP_CLEAR_INIT, 8'h32, sci_pkg::RC_OK, sci_pkg::RS_NONE, 1'b0);
        PKG_EVT <= 1'b1;
        settle(4);
        chk("package event", 32'hf, 32'(CH_IN_INIT));
        PKG_EVT <= 1'b0;
        settle(4);
        cmd(5'h01, sci_pkg::OP_CLEAR_INIT, 8'h40, sci_pkg::RC_OK, sci_pkg::RS_NONE, 1'b0);
        cmd(5'h02, sci_pkg::OP_CLEAR_INIT, 8'h41, sci_pkg::RC_OK, sci_pkg::RS_NONE, 1'b0);
        CH_EVT <= 4'h4;
        settle(4);
        chk("channel event", 32'hd, 32'(CH_IN_INIT));
        CH_EVT <= 4'h0;
        PWR_UP <= 1'b1;
        settle(5);
        chk("power-up entry", 32'hf, 32'(CH_IN_INIT));
        reg_rd(sci_pkg::OFS_STATUS, d);
        chk("arb on at power-up", 32'h1, 32'(d[11]));
        give_verdict();
    end

endmodule : tb
